// File: logic/tbe_pkg.sv
// tbe_pkg: constants, types and tables for the tdma burst encoder.
// assumes a 10 MHz system clock and a symbol period of eight system clocks.
package tbe_pkg;

	// buffer geometry
	localparam int WORD_BITS = 11;
	localparam int BUF_DEPTH = 64;
	localparam int ADDR_W = 6;
	localparam int BITCNT_W = 10;
	localparam logic [3:0] WORD_BITS_C = 4'hB;
	localparam logic [3:0] WORD_LAST_BIT = 4'hA;
	localparam logic [BITCNT_W-1:0] BIT_MAX = 10'h2C0;

	// timing: symbol period in ns, cycles derived from the clock period
	localparam int CLK_PERIOD_NS = 100;
	localparam int SYM_PERIOD_NS = 800;
	localparam int SYM_CYC = SYM_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] SYM_LAST = 3'(SYM_CYC - 1);

	// steps inside one symbol period
	localparam logic [2:0] STEP_MSB = 3'h0;
	localparam logic [2:0] STEP_NSB = 3'h1;
	localparam logic [2:0] STEP_CODE = 3'h2;
	localparam logic [2:0] STEP_FORM = 3'h3;
	localparam logic [2:0] STEP_OUT = 3'h4;
	localparam logic [2:0] STEP_CLK = 3'h5;

	// burst framing
	localparam logic [6:0] PRE_LAST = 7'h3F;
	localparam logic [6:0] PRE_ALT_END = 7'h20;
	localparam logic [6:0] UW_LAST = 7'h05;
	localparam logic [BITCNT_W-1:0] TERM_BITS = 10'h010;
	localparam logic [3:0] TERM_SYM_LAST = 4'h7;

	// tones and reset values
	localparam logic [3:0] LOWEST_TONE_SYMBOL = 4'h0;
	localparam logic [3:0] HIGHEST_TONE_SYMBOL = 4'hF;
	localparam logic [3:0] SYM_RESET = 4'h0;
	localparam logic [5:0] ENC_RESET = 6'h00;

	// rate 1/2 constraint 7 generators (octal 171 and 133)
	localparam logic [6:0] ENC_G1 = 7'h79;
	localparam logic [6:0] ENC_G2 = 7'h5B;

	// unique word table, four patterns of six tones; values arbitrary
	localparam logic [3:0] UW_TABLE [4][6] = '{
		'{4'h8, 4'h0, 4'h8, 4'h8, 4'h0, 4'h0},
		'{4'h0, 4'h8, 4'h0, 4'h0, 4'h8, 4'h8},
		'{4'h8, 4'h8, 4'h0, 4'h8, 4'h0, 4'h8},
		'{4'h0, 4'h0, 4'h8, 4'h0, 4'h8, 4'h8}
	};

	typedef enum logic [4:0] {
		TBE_IDLE = 5'b00001,
		TBE_CAPT = 5'b00010,
		TBE_PRE = 5'b00100,
		TBE_UW = 5'b01000,
		TBE_DATA = 5'b10000
	} tbe_state_e;

	typedef struct packed {
		logic [1:0] direct;
		logic [1:0] coded;
	} tbe_symbol_s;

endpackage

// File: logic/tbe_burst_encoder.sv
// tbe_burst_encoder: captures serial burst data into a buffer and emits
// preamble, unique word and coded data symbols to the modulator.
// assumes ser_clk_in, ser_data_in, burst_cmd_in and uw_sel_in are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none

module tbe_burst_encoder
	import tbe_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic ser_clk_in,
	input wire logic ser_data_in,
	input wire logic burst_cmd_in,
	input wire logic [1:0] uw_sel_in,
	output logic [3:0] sym_out,
	output logic sym_clk_out,
	output logic ready_out
);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	// parity of the tapped encoder register
	function automatic logic conv_bit(input logic [6:0] taps, input logic [6:0] gen);
		return ^(taps & gen);
	endfunction

	// phase difference from previous point to current point, modulo sixteen
	function automatic logic [3:0] phase_diff(input logic [3:0] cur, input logic [3:0] prev);
		return 4'(cur - prev);
	endfunction

	// two-flop synchronisers for every pin, one lane per bit
	localparam int SYNC_W = 5;
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [2:0] edge_q;
	assign pin_raw = {uw_sel_in, burst_cmd_in, ser_data_in, ser_clk_in};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys_in)
			begin
				if (!rstn_in)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// edge detection looks only at the second stage and its delayed copy
	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			edge_q <= 3'h0;
		else
			edge_q <= sync2_q[2:0];
	end

	logic ser_rise;
	logic ser_dat;
	logic cmd_rise;
	logic cmd_fall;
	assign ser_rise = sync2_q[0] & ~edge_q[0];
	assign ser_dat = sync2_q[1];
	assign cmd_rise = sync2_q[2] & ~edge_q[2];
	assign cmd_fall = ~sync2_q[2] & edge_q[2];

	tbe_state_e state_q;
	tbe_state_e state_d;
	logic [2:0] cnt_q;
	logic [6:0] idx_q;
	logic [BITCNT_W-1:0] rem_q;
	logic [1:0] phase;
	logic sym_end;
	assign phase = idx_q[1:0];
	assign sym_end = (cnt_q == SYM_LAST);

	// burst sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			TBE_IDLE: if (cmd_rise) state_d = TBE_CAPT;
			TBE_CAPT: if (cmd_fall) state_d = TBE_PRE;
			TBE_PRE: if (sym_end && idx_q == PRE_LAST) state_d = TBE_UW;
			TBE_UW: if (sym_end && idx_q == UW_LAST) state_d = TBE_DATA;
			TBE_DATA: if (sym_end && rem_q == '0) state_d = TBE_IDLE;
			default: state_d = TBE_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			state_q <= TBE_IDLE;
		else
			state_q <= state_d;
	end

	chk_fall_start: assert property (state_q == TBE_CAPT && cmd_fall |=> state_q == TBE_PRE)
		else $error("burst command fall did not start preamble");

	// capture: shift register, holding register and buffer write
	logic [WORD_BITS-1:0] ram [BUF_DEPTH];
	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] hold_q;
	logic [3:0] bcnt_q;
	logic wr_req_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [BITCNT_W-1:0] total_q;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			shift_q <= '0;
			hold_q <= '0;
			bcnt_q <= 4'h0;
			wr_req_q <= 1'b0;
			wr_addr_q <= '0;
			total_q <= '0;
		end
		else
		begin
			wr_req_q <= 1'b0;
			if (wr_req_q)
				wr_addr_q <= wr_addr_q + 1'b1;
			if (state_q == TBE_IDLE && cmd_rise)
			begin
				bcnt_q <= 4'h0;
				wr_addr_q <= '0;
				total_q <= '0;
			end
			else if (state_q == TBE_CAPT && cmd_fall)
			begin
				// a partial last word is left aligned, unused bits zero
				if (bcnt_q != 4'h0)
				begin
					hold_q <= shift_q << (WORD_BITS_C - bcnt_q);
					wr_req_q <= 1'b1;
				end
			end
			else if (state_q == TBE_CAPT && ser_rise && total_q != BIT_MAX)
			begin
				shift_q <= {shift_q[WORD_BITS-2:0], ser_dat};
				total_q <= total_q + 1'b1;
				if (bcnt_q == WORD_LAST_BIT)
				begin
					hold_q <= {shift_q[WORD_BITS-2:0], ser_dat};
					wr_req_q <= 1'b1;
					bcnt_q <= 4'h0;
				end
				else
					bcnt_q <= bcnt_q + 1'b1;
			end
		end
	end

	// buffer memory has no reset; only written words are ever read
	always_ff @(posedge clk_sys_in)
	begin
		if (wr_req_q)
			ram[wr_addr_q] <= hold_q;
	end

	chk_word_write: assert property (wr_req_q |=> wr_addr_q == $past(wr_addr_q) + 1'b1)
		else $error("buffer word write did not advance address");

	// symbol timing: step counter and symbol index
	logic tx;
	assign tx = (state_q == TBE_PRE) || (state_q == TBE_UW) || (state_q == TBE_DATA);

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			cnt_q <= 3'h0;
			idx_q <= 7'h00;
		end
		else if (!tx)
		begin
			cnt_q <= 3'h0;
			idx_q <= 7'h00;
		end
		else
		begin
			cnt_q <= sym_end ? 3'h0 : cnt_q + 1'b1;
			if (sym_end)
				idx_q <= (state_d != state_q) ? 7'h00 : idx_q + 1'b1;
		end
	end

	sequence s_pre_last;
		state_q == TBE_PRE && sym_end && idx_q == PRE_LAST;
	endsequence
	chk_pre_length: assert property (s_pre_last |=> state_q == TBE_UW && idx_q == 7'h00)
		else $error("preamble did not last 64 symbols");
	chk_uw_length: assert property (state_q == TBE_UW && sym_end && idx_q == UW_LAST |=> state_q == TBE_DATA)
		else $error("unique word did not last six symbols");

	// buffer bit reader, most significant bit of each word first
	logic [ADDR_W-1:0] rd_addr_q;
	logic [3:0] rd_off_q;
	logic [WORD_BITS-1:0] rd_word;
	logic rd_bit;
	logic term_q;
	logic pull_now;
	assign rd_word = ram[rd_addr_q];
	assign rd_bit = (rem_q != '0) ? rd_word[4'(WORD_LAST_BIT - rd_off_q)] : 1'b0;
	assign pull_now = (state_q == TBE_DATA) && ((cnt_q == STEP_MSB) || (cnt_q == STEP_NSB)
		|| (cnt_q == STEP_CODE && phase != 2'h3 && !term_q));

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			rd_addr_q <= '0;
			rd_off_q <= 4'h0;
			rem_q <= '0;
		end
		else if (state_q == TBE_PRE)
		begin
			rd_addr_q <= '0;
			rd_off_q <= 4'h0;
			rem_q <= total_q;
		end
		else if (pull_now && rem_q != '0)
		begin
			rem_q <= rem_q - 1'b1;
			rd_off_q <= (rd_off_q == WORD_LAST_BIT) ? 4'h0 : rd_off_q + 1'b1;
			if (rd_off_q == WORD_LAST_BIT)
				rd_addr_q <= rd_addr_q + 1'b1;
		end
	end

	// symbol assembly, convolutional encoder and current/previous registers
	logic [5:0] enc_q;
	tbe_symbol_s part_q;
	tbe_symbol_s a_q;
	tbe_symbol_s b_q;
	logic [3:0] term_cnt_q;
	logic code_in;
	logic [6:0] taps;
	assign code_in = term_q ? 1'b0 : rd_bit;
	assign taps = {code_in, enc_q};

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			enc_q <= ENC_RESET;
			part_q <= '0;
			a_q <= '0;
			b_q <= '0;
			term_q <= 1'b0;
			term_cnt_q <= 4'h0;
		end
		else if (state_q == TBE_PRE)
		begin
			// every burst starts from a known encoder and phase point
			enc_q <= ENC_RESET;
			a_q <= '0;
			b_q <= '0;
			term_q <= 1'b0;
			term_cnt_q <= 4'h0;
		end
		else if (state_q == TBE_DATA)
		begin
			case (cnt_q)
				STEP_MSB:
				begin
					part_q.direct[1] <= rd_bit;
					if (phase == 2'h0 && rem_q <= TERM_BITS)
						term_q <= 1'b1;
				end
				STEP_NSB: part_q.direct[0] <= rd_bit;
				STEP_CODE:
				begin
					if (phase != 2'h3)
					begin
						part_q.coded <= {conv_bit(taps, ENC_G1), conv_bit(taps, ENC_G2)};
						enc_q <= {enc_q[4:0], code_in};
					end
					else
						part_q.coded <= 2'h0;
				end
				STEP_FORM:
				begin
					a_q <= part_q;
					b_q <= a_q;
				end
				SYM_LAST: if (term_q) term_cnt_q <= term_cnt_q + 1'b1;
				default: ;
			endcase
		end
	end

	chk_fourth_zero: assert property (state_q == TBE_DATA && cnt_q == STEP_FORM && phase == 2'h3 |=> a_q.coded == 2'h0)
		else $error("fourth symbol lower bits not zero");
	chk_enc_pause: assert property (state_q == TBE_DATA && cnt_q == STEP_CODE && phase == 2'h3 |=> $stable(enc_q))
		else $error("encoder advanced on fourth symbol");
	chk_term_zero: assert property (state_q == TBE_DATA && term_q && cnt_q == STEP_CODE && phase != 2'h3
		|=> enc_q == {$past(enc_q[4:0]), 1'b0})
		else $error("tail did not feed zero to encoder");
	chk_term_flush: assert property (state_q == TBE_DATA && sym_end && rem_q == '0 && term_cnt_q == TERM_SYM_LAST
		|-> enc_q == ENC_RESET)
		else $error("encoder not flushed after eight tail symbols");
	chk_enc_clear: assert property (state_q == TBE_PRE && idx_q != 7'h00 |-> enc_q == ENC_RESET)
		else $error("encoder not cleared for new burst");

	// output register and symbol clock; clock rises after the symbol settles
	logic [1:0] uw_pick_q;
	logic [3:0] sym_q;
	logic sym_clk_q;
	logic ready_q;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			uw_pick_q <= 2'h0;
			sym_q <= SYM_RESET;
			sym_clk_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			if (state_q == TBE_CAPT && cmd_fall)
				uw_pick_q <= sync2_q[4:3];
			sym_clk_q <= tx && (cnt_q >= STEP_CLK);
			ready_q <= (state_d == TBE_IDLE) || (state_d == TBE_CAPT);
			if (tx && cnt_q == STEP_OUT)
			begin
				case (state_q)
					TBE_PRE: sym_q <= (idx_q < PRE_ALT_END && idx_q[0]) ?
						HIGHEST_TONE_SYMBOL : LOWEST_TONE_SYMBOL;
					TBE_UW: sym_q <= UW_TABLE[uw_pick_q][3'(idx_q)];
					TBE_DATA: sym_q <= phase_diff(a_q, b_q);
					default: sym_q <= SYM_RESET;
				endcase
			end
		end
	end

	chk_pre_tone: assert property (state_q == TBE_PRE && cnt_q == STEP_OUT
		|=> sym_q == (($past(idx_q) < PRE_ALT_END && $past(idx_q[0])) ? HIGHEST_TONE_SYMBOL : LOWEST_TONE_SYMBOL))
		else $error("wrong preamble tone");
	chk_diff_out: assert property (state_q == TBE_DATA && cnt_q == STEP_OUT
		|=> sym_q == 4'($past(a_q) - $past(b_q)))
		else $error("difference symbol wrong");
	chk_done_idle: assert property (state_q == TBE_DATA && sym_end && rem_q == '0 |=> state_q == TBE_IDLE ##1 ready_out)
		else $error("encoder did not return to idle");

	assign sym_out = sym_q;
	assign sym_clk_out = sym_clk_q;
	assign ready_out = ready_q;

endmodule // tbe_burst_encoder

`default_nettype wire

// File: bench/tbe_link_partner.sv
// tbe_link_partner: user data source and modulator stand-in for the burst encoder.
// assumes the bench calls burst() while the encoder is ready; timing runs off its own delays.
`timescale 1ns/1ps
`default_nettype none

module tbe_link_partner
	import tbe_pkg::*;
(
	input wire logic [3:0] sym_in,
	input wire logic sym_clk_in,
	output logic ser_clk_out,
	output logic ser_data_out,
	output logic burst_cmd_out
);
	logic [3:0] syms[$];
	realtime tms[$];

	initial
	begin
		ser_clk_out = 1'b0;
		ser_data_out = 1'b0;
		burst_cmd_out = 1'b0;
	end

	// modulator side: take each symbol on the rising symbol clock, keep its time
	always @(posedge sym_clk_in)
	begin
		syms.push_back(sym_in);
		tms.push_back($realtime);
	end

	// source side: link clock runs only inside the frame, 800 ns period
	task automatic burst(input logic [63:0] pat, input int n);
		int i;
		burst_cmd_out = 1'b1;
		#400;
		for (i = 0; i < n; i++)
		begin
			ser_data_out = pat[63-i]; // first bit on the wire is the word msb
			#400 ser_clk_out = 1'b1;
			#400 ser_clk_out = 1'b0;
		end
		// released data line must not keep looking valid
		ser_data_out = ~ser_data_out;
		#500 burst_cmd_out = 1'b0;
	endtask
endmodule // tbe_link_partner

`default_nettype wire

// File: bench/tdma_burst_encoder_tb.sv
// tdma_burst_encoder_tb: self-checking bench, bursts of several lengths and patterns.
// assumes tbe_pkg constants and the partner model in tbe_link_partner.
`timescale 1ns/1ps
`default_nettype none

module tdma_burst_encoder_tb
	import tbe_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [1:0] uw_sel_in = 2'h0;
	wire logic ser_clk, ser_data, burst_cmd;
	wire logic [3:0] sym_out;
	wire logic sym_clk_out, ready_out;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;

	always #50 clk_sys_in = ~clk_sys_in;

	tbe_burst_encoder uut (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.ser_clk_in(ser_clk),
		.ser_data_in(ser_data),
		.burst_cmd_in(burst_cmd),
		.uw_sel_in(uw_sel_in),
		.sym_out(sym_out),
		.sym_clk_out(sym_clk_out),
		.ready_out(ready_out)
	);

	tbe_link_partner p (
		.sym_in(sym_out),
		.sym_clk_in(sym_clk_out),
		.ser_clk_out(ser_clk),
		.ser_data_out(ser_data),
		.burst_cmd_out(burst_cmd)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	// cut a hang short; four bursts need well under 8000 cycles
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			$display("ERROR %0t run took too long", $time);
			end_sim();
		end
	end

	task automatic t_reset();
		repeat (4) @(negedge clk_sys_in);
		check(sym_out === SYM_RESET && ready_out === 1'b0, "outputs not quiet in reset");
		repeat (4) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check(ready_out === 1'b1 && sym_clk_out === 1'b0, "not ready after reset");
		$display("test reset done");
	endtask

	// one burst: expected preamble, unique word and coded data built from the bits
	task automatic t_burst(input logic [1:0] sel, input int n, input logic [63:0] pat);
		logic [3:0] exp[$];
		logic [5:0] st;
		logic [6:0] r;
		logic [3:0] a, b;
		logic inb, tail;
		int i, ph, k;
		for (i = 0; i < 16; i++)
		begin
			exp.push_back(LOWEST_TONE_SYMBOL);
			exp.push_back(HIGHEST_TONE_SYMBOL);
		end
		for (i = 0; i < 32; i++)
			exp.push_back(LOWEST_TONE_SYMBOL);
		for (i = 0; i < 6; i++)
			exp.push_back(UW_TABLE[sel][i]);
		// encoder from zero each burst; tail bits all direct with zeros encoded
		st = ENC_RESET;
		b = SYM_RESET;
		i = 0;
		ph = 0;
		tail = 1'b0;
		while (i < n)
		begin
			if (ph == 0 && n - i <= 16)
				tail = 1'b1;
			a[3:2] = {pat[63-i], pat[62-i]};
			i += 2;
			if (ph == 3)
				a[1:0] = 2'b00;
			else
			begin
				inb = tail ? 1'b0 : pat[63-i];
				if (!tail)
					i++;
				r = {inb, st};
				a[1:0] = {^(r & ENC_G1), ^(r & ENC_G2)};
				st = {st[4:0], inb};
			end
			exp.push_back(4'(a - b));
			b = a;
			ph = (ph + 1) % 4;
		end
		@(negedge clk_sys_in);
		uw_sel_in = sel;
		p.syms.delete();
		p.tms.delete();
		p.burst(pat, n);
		k = 0;
		while (ready_out !== 1'b0 && k < 20)
		begin
			@(negedge clk_sys_in);
			k++;
		end
		check(ready_out === 1'b0, "burst request not taken");
		// selection is held from the burst command fall; a late change must not matter
		repeat (6) @(negedge clk_sys_in);
		uw_sel_in = ~sel;
		k = 0;
		while (ready_out !== 1'b1 && k < 3000)
		begin
			@(negedge clk_sys_in);
			k++;
		end
		check(ready_out === 1'b1, "no return to ready");
		repeat (16) @(negedge clk_sys_in);
		check(sym_clk_out === 1'b0, "symbol clock runs while idle");
		check(p.syms.size() == exp.size(), "wrong symbol count");
		for (i = 0; i < exp.size() && i < p.syms.size(); i++)
		begin
			check(p.syms[i] === exp[i], $sformatf("symbol %0d wrong", i));
			if (i > 0)
				check(p.tms[i] - p.tms[i-1] == 800.0, "symbol spacing");
		end
		$display("test burst sel %0d bits %0d done", sel, n);
	endtask

	initial
	begin
		t_reset();
		t_burst(2'h0, 16, 64'hA5C3_0000_0000_0000);
		t_burst(2'h1, 27, 64'hFFFF_E000_0000_0000);
		t_burst(2'h2, 38, 64'h9B47_E1D2_C000_0000);
		t_burst(2'h3, 27, 64'h5F0C_6000_0000_0000);
		end_sim();
	end
endmodule // tdma_burst_encoder_tb

`default_nettype wire
